// ===== logic/opa_pkg.sv
package opa_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_PIN_SEL = 8'h00;
  localparam logic [7:0] OFF_AUX_CTRL = 8'h04;
  localparam logic [7:0] OFF_GEN_OUT = 8'h08;
  localparam logic [7:0] OFF_CT_PRELOAD = 8'h0c;
  localparam logic [7:0] OFF_CT_CMD = 8'h10;
  localparam logic [7:0] OFF_INT_STATUS = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;
  localparam logic [7:0] OFF_CHG_FLAGS = 8'h1c;
  localparam logic [7:0] OFF_CSEL_A = 8'h20;
  localparam logic [7:0] OFF_CSEL_B = 8'h24;

  // Values after reset
  localparam logic [7:0] RST_PIN_SEL = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL = 8'h00;
  localparam logic [7:0] RST_GEN_OUT = 8'h00;
  localparam logic [7:0] RST_INT_MASK = 8'h00;
  localparam logic [15:0] RST_CT_PRELOAD = 16'h0002;
  localparam logic [3:0] RST_CSEL = 4'h0;

  // Field positions
  localparam int AUX_SET2_BIT = 7;
  localparam int AUX_CT_LSB = 4;
  localparam int ISR_CHG_BIT = 7;
  localparam int ISR_B_TXRDY_BIT = 4;
  localparam int ISR_CT_BIT = 3;
  localparam int ISR_A_TXRDY_BIT = 0;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;

  // Counter/timer mode and clock source codes
  localparam logic [2:0] CT_CNT_IP2 = 3'h0;
  localparam logic [2:0] CT_CNT_ATX = 3'h1;
  localparam logic [2:0] CT_CNT_BTX = 3'h2;
  localparam logic [2:0] CT_CNT_XD16 = 3'h3;
  localparam logic [2:0] CT_TMR_IP2 = 3'h4;
  localparam logic [2:0] CT_TMR_IPD16 = 3'h5;
  localparam logic [2:0] CT_TMR_X = 3'h6;
  localparam logic [2:0] CT_TMR_XD16 = 3'h7;

  // Pin select codes for the two-bit fields
  localparam logic [1:0] PSEL_GEN = 2'h0;
  localparam logic [1:0] PSEL_AUX = 2'h1;
  localparam logic [1:0] PSEL_TX1X = 2'h2;
  localparam logic [1:0] PSEL_RX1X = 2'h3;

  // Clock select code that passes the external 1X clock
  localparam logic [3:0] CSEL_EXT_1X = 4'hf;
  localparam logic [3:0] PRESCALE_LAST = 4'hf;

  // Reference edges per 16X period: 3.6864 MHz / (16 * rate), rounded
  localparam logic [12:0] BRG_DIV_SET1 [13] = '{
    13'd4608, 13'd2095, 13'd1713, 13'd1152, 13'd768, 13'd384, 13'd219,
    13'd192, 13'd96, 13'd48, 13'd32, 13'd24, 13'd6};
  localparam logic [12:0] BRG_DIV_SET2 [13] = '{
    13'd3072, 13'd2095, 13'd1713, 13'd1536, 13'd768, 13'd384, 13'd192,
    13'd128, 13'd115, 13'd96, 13'd48, 13'd24, 13'd12};
  localparam int BRG_RATES = 13;

endpackage

// ===== logic/opa_brg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface opa_brg_if;
  logic xtal_edge;
  logic set2;
  logic [3:0] csel;
  logic ext_1x;
  logic clk16;
  modport ctrl (output xtal_edge, output set2, output csel, output ext_1x,
                input clk16);
  modport gen (input xtal_edge, input set2, input csel, input ext_1x,
               output clk16);
endinterface
`default_nettype wire

// ===== logic/opa_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
module opa_baud_gen
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Rate selection and 16X clock
  opa_brg_if.gen brg
);

  typedef struct packed {
    logic [12:0] cnt;
    logic clk16;
  } opa_brg_state_t;

  opa_brg_state_t s_q, s_d;

  // Divisor lookup for one rate code of the chosen set
  function automatic logic [12:0] opa_div(input logic set2,
                                          input logic [3:0] code);
    logic [12:0] d;
    d = opa_pkg::BRG_DIV_SET1[0];
    if (int'(code) < opa_pkg::BRG_RATES)
    begin
      d = set2 ? opa_pkg::BRG_DIV_SET2[code] : opa_pkg::BRG_DIV_SET1[code];
    end
    return d;
  endfunction

  // Count reference edges; high for the first half of each period
  always_comb
  begin
    logic [12:0] div;
    div = opa_div(brg.set2, brg.csel);
    s_d = s_q;
    if (brg.xtal_edge)
    begin
      if (s_q.cnt >= div - 13'd1)
        s_d.cnt = 13'h0000;
      else
        s_d.cnt = s_q.cnt + 13'd1;
    end
    s_d.clk16 = (s_q.cnt < (div >> 1));
    if (brg.csel == opa_pkg::CSEL_EXT_1X)
      s_d.clk16 = brg.ext_1x; // Selected external 1X clock
  end

  // State register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign brg.clk16 = s_q.clk16;

endmodule
`default_nettype wire

// ===== logic/opa_output_port_aux.sv
`timescale 1ns/10ps
`default_nettype none
module opa_output_port_aux
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from outside
  input wire logic crystal_clock_input,
  input wire logic [3:0] input_pins,
  // Channel logic on this clock
  input wire logic chan_a_tx_ready,
  input wire logic chan_b_tx_ready,
  input wire logic chan_a_rx_status,
  input wire logic chan_b_rx_status,
  input wire logic chan_a_tx_bit_clock,
  input wire logic chan_a_rx_bit_clock,
  input wire logic chan_b_tx_bit_clock,
  input wire logic chan_b_rx_bit_clock,
  // Baud clocks to the channels
  output logic chan_a_clk16,
  output logic chan_b_clk16,
  // Output pins two to seven, index 0 is pin two
  output logic [5:0] output_pin_o,
  output logic [5:0] output_pin_oe_n,
  // Input change interrupt request
  output logic input_change_irq
);

  typedef struct packed {
    logic xtal_s1;
    logic xtal_s2;
    logic xtal_prev;
    logic [3:0] ip_s1;
    logic [3:0] ip_s2;
    logic [3:0] ip_prev;
    logic [3:0] xtal_div;
    logic [3:0] ip2_div;
    logic atx_prev;
    logic btx_prev;
    logic [7:0] pin_sel;
    logic [7:0] aux_ctrl;
    logic [7:0] gen_out;
    logic [7:0] int_mask;
    logic [3:0] csel_a;
    logic [3:0] csel_b;
    logic [15:0] preload;
    logic [15:0] count;
    logic ct_run;
    logic ct_out;
    logic ct_ready;
    logic sq_phase;
    logic [3:0] chg;
    logic chg_int;
    logic ack;
    logic slverr;
    logic [31:0] rdata;
    logic [5:0] pin_o;
    logic [5:0] pin_oe_n;
    logic irq;
  } opa_state_t;

  opa_state_t s_q, s_d;
  opa_brg_if brg_a ();
  opa_brg_if brg_b ();

  // One baud generator per channel, both fed from the same rate set
  opa_baud_gen u_brg_a
  (
    .clk (clk),
    .reset (reset),
    .brg (brg_a.gen)
  );

  opa_baud_gen u_brg_b
  (
    .clk (clk),
    .reset (reset),
    .brg (brg_b.gen)
  );

  // Rate set and per-channel select into the generators
  assign brg_a.xtal_edge = s_q.xtal_s2 & ~s_q.xtal_prev;
  assign brg_a.set2 = s_q.aux_ctrl[opa_pkg::AUX_SET2_BIT];
  assign brg_a.csel = s_q.csel_a;
  assign brg_a.ext_1x = chan_a_tx_bit_clock;
  assign brg_b.xtal_edge = s_q.xtal_s2 & ~s_q.xtal_prev;
  assign brg_b.set2 = s_q.aux_ctrl[opa_pkg::AUX_SET2_BIT];
  assign brg_b.csel = s_q.csel_b;
  assign brg_b.ext_1x = chan_b_tx_bit_clock;

  // Next-state logic of the whole block
  always_comb
  begin
    logic xtal_edge;
    logic ip2_edge;
    logic xd16_edge;
    logic ipd16_edge;
    logic ct_edge;
    logic timer_mode;
    logic [2:0] ct_mode;
    logic wr_done;
    logic rd_take;
    logic start_cmd;
    logic stop_cmd;
    logic [3:0] chg_set;
    logic [3:0] src_sel;
    logic [3:0] src_val;
    logic [7:0] interrupt_status;
    logic [31:0] rd;
    logic bad;
    logic od;
    logic val;

    // All locals start at zero so no path leaves one stale
    {xtal_edge, ip2_edge, xd16_edge, ipd16_edge, ct_edge, timer_mode,
     ct_mode, wr_done, rd_take, start_cmd, stop_cmd, chg_set, src_sel,
     src_val, interrupt_status, rd, bad, od, val} = '0;
    s_d = s_q;

    // Two flip-flops on every pin input before use
    s_d.xtal_s1 = crystal_clock_input;
    s_d.xtal_s2 = s_q.xtal_s1;
    s_d.xtal_prev = s_q.xtal_s2;
    s_d.ip_s1 = input_pins;
    s_d.ip_s2 = s_q.ip_s1;
    s_d.ip_prev = s_q.ip_s2;
    s_d.atx_prev = chan_a_tx_bit_clock;
    s_d.btx_prev = chan_b_tx_bit_clock;

    // Edges of the counter sources, with divide-by-16 prescalers
    xtal_edge = s_q.xtal_s2 & ~s_q.xtal_prev;
    ip2_edge = s_q.ip_s2[2] & ~s_q.ip_prev[2];
    xd16_edge = xtal_edge && (s_q.xtal_div == opa_pkg::PRESCALE_LAST);
    ipd16_edge = ip2_edge && (s_q.ip2_div == opa_pkg::PRESCALE_LAST);
    if (xtal_edge)
      s_d.xtal_div = s_q.xtal_div + 4'h1;
    if (ip2_edge)
      s_d.ip2_div = s_q.ip2_div + 4'h1;

    ct_mode = s_q.aux_ctrl[opa_pkg::AUX_CT_LSB +: 3];
    timer_mode = ct_mode[2];
    case (ct_mode)
      opa_pkg::CT_CNT_IP2: ct_edge = ip2_edge;
      opa_pkg::CT_CNT_ATX: ct_edge = chan_a_tx_bit_clock & ~s_q.atx_prev;
      opa_pkg::CT_CNT_BTX: ct_edge = chan_b_tx_bit_clock & ~s_q.btx_prev;
      opa_pkg::CT_CNT_XD16: ct_edge = xd16_edge;
      opa_pkg::CT_TMR_IP2: ct_edge = ip2_edge;
      opa_pkg::CT_TMR_IPD16: ct_edge = ipd16_edge;
      opa_pkg::CT_TMR_X: ct_edge = xtal_edge;
      opa_pkg::CT_TMR_XD16: ct_edge = xd16_edge;
      default: ct_edge = 1'b0;
    endcase

    // APB: one wait state; effects land on the edge pready is seen
    s_d.ack = psel & penable & ~s_q.ack;
    wr_done = psel & penable & s_q.ack & pwrite;
    rd_take = psel & penable & ~s_q.ack & ~pwrite;
    start_cmd = wr_done && (paddr == opa_pkg::OFF_CT_CMD) &&
                pwdata[opa_pkg::CMD_START_BIT];
    stop_cmd = wr_done && (paddr == opa_pkg::OFF_CT_CMD) &&
               pwdata[opa_pkg::CMD_STOP_BIT];

    // Configuration writes
    if (wr_done)
    begin
      case (paddr)
        opa_pkg::OFF_PIN_SEL: s_d.pin_sel = pwdata[7:0];
        opa_pkg::OFF_AUX_CTRL: s_d.aux_ctrl = pwdata[7:0];
        opa_pkg::OFF_GEN_OUT: s_d.gen_out = pwdata[7:0];
        opa_pkg::OFF_CT_PRELOAD: s_d.preload = pwdata[15:0];
        opa_pkg::OFF_INT_MASK: s_d.int_mask = pwdata[7:0];
        opa_pkg::OFF_CSEL_A: s_d.csel_a = pwdata[3:0];
        opa_pkg::OFF_CSEL_B: s_d.csel_b = pwdata[3:0];
        default: s_d.pin_sel = s_q.pin_sel;
      endcase
    end

    // Stop first, so a terminal count in the same cycle still sets ready
    if (stop_cmd)
    begin
      s_d.ct_ready = 1'b0;
      if (!timer_mode)
      begin
        s_d.ct_run = 1'b0;
        s_d.ct_out = 1'b1; // Back high on stop
      end
    end

    // Counter/timer core
    if (start_cmd)
    begin
      s_d.ct_run = 1'b1;
      s_d.count = s_q.preload;
      s_d.sq_phase = 1'b1;
      s_d.ct_out = 1'b1;
    end
    else if (s_q.ct_run && ct_edge)
    begin
      if (timer_mode)
      begin
        // Half period equals the preload, so the period is twice it
        if (s_q.count <= 16'h0001)
        begin
          s_d.count = s_q.preload;
          s_d.sq_phase = ~s_q.sq_phase;
          if (!s_q.sq_phase)
            s_d.ct_ready = 1'b1;
        end
        else
          s_d.count = s_q.count - 16'h0001;
      end
      else
      begin
        // Keeps counting past terminal count until stopped
        s_d.count = s_q.count - 16'h0001;
        if (s_q.count == 16'h0001)
        begin
          s_d.ct_ready = 1'b1;
          s_d.ct_out = stop_cmd; // Low at terminal count, high if stopped in the same cycle
        end
      end
    end

    // Input change; a read clears only the flags it returned
    chg_set = s_q.ip_s2 ^ s_q.ip_prev;
    if (wr_done == 1'b0 && psel && penable && s_q.ack &&
        paddr == opa_pkg::OFF_CHG_FLAGS)
    begin
      s_d.chg = s_q.chg & ~s_q.rdata[7:4];
      s_d.chg_int = 1'b0;
    end
    s_d.chg = s_d.chg | chg_set;
    if (|(chg_set & s_q.aux_ctrl[3:0]))
      s_d.chg_int = 1'b1;

    // Status as software sees it
    interrupt_status = 8'h00;
    interrupt_status[opa_pkg::ISR_CHG_BIT] = s_q.chg_int;
    interrupt_status[6] = 1'b0;
    interrupt_status[5] = chan_b_rx_status;
    interrupt_status[opa_pkg::ISR_B_TXRDY_BIT] = chan_b_tx_ready;
    interrupt_status[opa_pkg::ISR_CT_BIT] = s_q.ct_ready;
    interrupt_status[1] = chan_a_rx_status;
    interrupt_status[opa_pkg::ISR_A_TXRDY_BIT] = chan_a_tx_ready;
    s_d.irq = s_q.chg_int & s_q.int_mask[opa_pkg::ISR_CHG_BIT];

    // Read data; pin select, aux control, preload and command registers are write-only and read zero
    rd = 32'h0000_0000;
    bad = 1'b0;
    case (paddr)
      opa_pkg::OFF_PIN_SEL, opa_pkg::OFF_AUX_CTRL,
      opa_pkg::OFF_CT_PRELOAD, opa_pkg::OFF_CT_CMD: rd = 32'h0000_0000;
      opa_pkg::OFF_GEN_OUT: rd = {24'h00_0000, s_q.gen_out};
      opa_pkg::OFF_INT_STATUS: rd = {24'h00_0000, interrupt_status};
      opa_pkg::OFF_INT_MASK: rd = {24'h00_0000, s_q.int_mask};
      opa_pkg::OFF_CHG_FLAGS: rd = {24'h00_0000, s_q.chg, s_q.ip_s2};
      opa_pkg::OFF_CSEL_A: rd = {28'h000_0000, s_q.csel_a};
      opa_pkg::OFF_CSEL_B: rd = {28'h000_0000, s_q.csel_b};
      default: bad = 1'b1;
    endcase
    if (rd_take)
      s_d.rdata = bad ? 32'h0000_0000 : rd;
    s_d.slverr = psel & penable & ~s_q.ack & bad; // Stands with pready

    // Pins four to seven: inverted output bit or an unmasked status line
    src_sel = s_q.pin_sel[7:4];
    src_val = {~chan_b_tx_ready, ~chan_a_tx_ready,
               ~chan_b_rx_status, ~chan_a_rx_status};
    for (int k = 0; k < 4; k++)
    begin
      // Open drain pulls low only; released means the pin floats high
      od = src_sel[k];
      val = od ? src_val[k] : ~s_q.gen_out[k + 4];
      s_d.pin_o[k + 2] = od ? 1'b0 : val;
      s_d.pin_oe_n[k + 2] = od ? val : 1'b0;
    end

    // Pin three
    od = 1'b0;
    case (s_q.pin_sel[3:2])
      opa_pkg::PSEL_GEN: val = ~s_q.gen_out[3];
      opa_pkg::PSEL_AUX:
      begin
        od = 1'b1;
        val = timer_mode ? s_q.sq_phase : s_q.ct_out;
      end
      opa_pkg::PSEL_TX1X: val = chan_b_tx_bit_clock;
      opa_pkg::PSEL_RX1X: val = chan_b_rx_bit_clock;
      default: val = 1'b1;
    endcase
    s_d.pin_o[1] = od ? 1'b0 : val;
    s_d.pin_oe_n[1] = od ? val : 1'b0;

    // Pin two
    case (s_q.pin_sel[1:0])
      opa_pkg::PSEL_GEN: val = ~s_q.gen_out[2];
      opa_pkg::PSEL_AUX: val = brg_a.clk16;
      opa_pkg::PSEL_TX1X: val = chan_a_tx_bit_clock;
      opa_pkg::PSEL_RX1X: val = chan_a_rx_bit_clock;
      default: val = 1'b1;
    endcase
    s_d.pin_o[0] = val;
    s_d.pin_oe_n[0] = 1'b0;
  end

  // State register; control state has fixed values after reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.pin_sel <= opa_pkg::RST_PIN_SEL;
      s_q.aux_ctrl <= opa_pkg::RST_AUX_CTRL;
      s_q.gen_out <= opa_pkg::RST_GEN_OUT;
      s_q.int_mask <= opa_pkg::RST_INT_MASK;
      s_q.csel_a <= opa_pkg::RST_CSEL;
      s_q.csel_b <= opa_pkg::RST_CSEL;
      s_q.preload <= opa_pkg::RST_CT_PRELOAD;
      s_q.ct_out <= 1'b1;
      s_q.sq_phase <= 1'b1;
      s_q.pin_o <= 6'h3f;
    end
    else
      s_q <= s_d;
  end

  // Outputs
  assign prdata = s_q.rdata;
  assign pready = s_q.ack;
  assign pslverr = s_q.slverr;
  assign chan_a_clk16 = brg_a.clk16;
  assign chan_b_clk16 = brg_b.clk16;
  assign output_pin_o = s_q.pin_o;
  assign output_pin_oe_n = s_q.pin_oe_n;
  assign input_change_irq = s_q.irq;

endmodule
`default_nettype wire

// ===== verif/opa_output_port_aux_sva.sv
`timescale 1ns/10ps
`default_nettype none
module opa_output_port_aux_sva
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and channel signals
  input wire logic crystal_clock_input,
  input wire logic [3:0] input_pins,
  input wire logic chan_a_tx_ready,
  input wire logic chan_b_tx_ready,
  input wire logic chan_a_rx_status,
  input wire logic chan_b_rx_status,
  input wire logic chan_a_tx_bit_clock,
  input wire logic chan_a_rx_bit_clock,
  input wire logic chan_b_tx_bit_clock,
  input wire logic chan_b_rx_bit_clock,
  // Block outputs
  input wire logic chan_a_clk16,
  input wire logic chan_b_clk16,
  input wire logic [5:0] output_pin_o,
  input wire logic [5:0] output_pin_oe_n,
  input wire logic input_change_irq
);
  logic [7:0] sel_q, aux_q, gen_q, mask_q;
  logic [3:0] src3, src2;
  logic wr, rd_chg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Completed APB cycles, at the edge the slave commits them
  assign wr = psel && penable && pready && pwrite;
  assign rd_chg = psel && penable && pready && !pwrite && paddr == 8'h1c;
  // Shadow of the settings the pins and the input change interrupt depend on
  always_ff @(posedge clk or posedge reset)
    if (reset)
      {sel_q, aux_q, gen_q, mask_q} <= 32'h0;
    else if (wr)
      case (paddr)
        8'h00: sel_q <= pwdata[7:0];
        8'h04: aux_q <= pwdata[7:0];
        8'h08: gen_q <= pwdata[7:0];
        8'h18: mask_q <= pwdata[7:0];
        default: ;
      endcase
  // Pin three and two sources, indexed by their select code
  assign src3 = {chan_b_rx_bit_clock, chan_b_tx_bit_clock, 1'b0, !gen_q[3]};
  assign src2 = {chan_a_rx_bit_clock, chan_a_tx_bit_clock, chan_a_clk16,
    !gen_q[2]};
  // Open-drain pin as {o, oe_n}: inverted general bit or inverted flag
  function automatic logic [1:0] od(input logic s, input logic g,
    input logic f);
    return s ? {1'b0, !f} : {!g, 1'b0};
  endfunction
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_ack;
    pready ##1 !pready;
  endsequence
  a_pin_seven: assert property (
    {output_pin_o[5], output_pin_oe_n[5]} ==
    $past(od(sel_q[7], gen_q[7], chan_b_tx_ready)))
    else $error("pin seven wrong");
  a_pin_six: assert property (
    {output_pin_o[4], output_pin_oe_n[4]} ==
    $past(od(sel_q[6], gen_q[6], chan_a_tx_ready)))
    else $error("pin six wrong");
  a_pin_five: assert property (
    {output_pin_o[3], output_pin_oe_n[3]} ==
    $past(od(sel_q[5], gen_q[5], chan_b_rx_status)))
    else $error("pin five wrong");
  a_pin_four: assert property (
    {output_pin_o[2], output_pin_oe_n[2]} ==
    $past(od(sel_q[4], gen_q[4], chan_a_rx_status)))
    else $error("pin four wrong");
  a_pin_three: assert property (
    output_pin_o[1] == $past(src3[sel_q[3:2]]) &&
    ($past(sel_q[3:2]) == 2'h1 || !output_pin_oe_n[1]))
    else $error("pin three wrong");
  a_pin_two: assert property (
    output_pin_o[0] == $past(src2[sel_q[1:0]]) && !output_pin_oe_n[0])
    else $error("pin two wrong");
  a_apb_wait: assert property (s_access |=> s_ack)
    else $error("apb answer wrong");
  a_irq_masked: assert property (
    !$past(mask_q[7]) |-> !input_change_irq)
    else $error("irq while masked");
  a_chg_clear: assert property (
    rd_chg |-> ##2 !input_change_irq)
    else $error("irq not cleared");
  a_chg_raise: assert property (
    (|((input_pins ^ $past(input_pins)) & aux_q[3:0]) && mask_q[7])
    |-> ##[2:8] input_change_irq)
    else $error("irq not raised");
endmodule
bind opa_output_port_aux opa_output_port_aux_sva i_opa_output_port_aux_sva (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .crystal_clock_input(crystal_clock_input), .input_pins(input_pins),
  .chan_a_tx_ready(chan_a_tx_ready), .chan_b_tx_ready(chan_b_tx_ready),
  .chan_a_rx_status(chan_a_rx_status), .chan_b_rx_status(chan_b_rx_status),
  .chan_a_tx_bit_clock(chan_a_tx_bit_clock),
  .chan_a_rx_bit_clock(chan_a_rx_bit_clock),
  .chan_b_tx_bit_clock(chan_b_tx_bit_clock),
  .chan_b_rx_bit_clock(chan_b_rx_bit_clock),
  .chan_a_clk16(chan_a_clk16), .chan_b_clk16(chan_b_clk16),
  .output_pin_o(output_pin_o), .output_pin_oe_n(output_pin_oe_n),
  .input_change_irq(input_change_irq));
`default_nettype wire

// ===== verif/opa_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module opa_far_side
(
  // Clock
  input wire logic clk,
  // Pins driven by the block
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe_n,
  // Reference and channel clocks
  output var logic xtal,
  output logic [3:0] bitclk,
  // Wire levels
  output logic [5:0] level
);
  logic [7:0] cnt_q = 8'h00;
  // Reference clock of four clk periods, changing on falling edges of clk, so the synchronisers work
  initial
  begin
    xtal = 1'b0;
    forever #50 xtal = ~xtal;
  end
  // Channel 1X clocks run all the time, idle line or not
  always @(posedge clk)
    cnt_q <= cnt_q + 8'h01;
  assign bitclk = {cnt_q[6], cnt_q[5], cnt_q[4], cnt_q[2]};
  // A released open-drain pin is pulled high
  assign level = pin_o | pin_oe_n;
endmodule
`default_nettype wire

// ===== verif/test_output_port_aux.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) \
    begin \
      bad_count++; \
      $display("BAD %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module test_output_port_aux;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] inp = 4'h0;
  logic [3:0] fl = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ca16, cb16, irq, xtal;
  logic [3:0] bclk;
  logic [5:0] po, poe, lvl;
  logic [1:0] prv;
  int bad_count = 0;
  int total_checks = 0;
  int n, e, t, lo, xcnt = 0;
  opa_output_port_aux i_opa_output_port_aux (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_clock_input(xtal),
    .input_pins(inp), .chan_a_tx_ready(fl[0]), .chan_b_tx_ready(fl[1]),
    .chan_a_rx_status(fl[2]), .chan_b_rx_status(fl[3]),
    .chan_a_tx_bit_clock(bclk[0]), .chan_a_rx_bit_clock(bclk[1]),
    .chan_b_tx_bit_clock(bclk[2]), .chan_b_rx_bit_clock(bclk[3]),
    .chan_a_clk16(ca16), .chan_b_clk16(cb16), .output_pin_o(po),
    .output_pin_oe_n(poe), .input_change_irq(irq));
  opa_far_side i_opa_far_side (.clk(clk), .pin_o(po), .pin_oe_n(poe),
    .xtal(xtal), .bitclk(bclk), .level(lvl));
  // Clock and reference edge count
  always #12.5 clk = ~clk;
  always @(posedge xtal) xcnt++;
  task automatic close_out;
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK("reset pins", 12'hfc0, {po, poe})
    apb(1'b0, 8'h00, 32'h0);
    `CHK("wo read", 32'h0, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", {1'b1, 32'h0}, {err, rd})
    apb(1'b1, 8'h08, 32'h5a);
    repeat (2) @(posedge clk);
    `CHK("gen pins", 6'h29, lvl)
    apb(1'b1, 8'h00, 32'hf0);
    for (int k = 0; k < 2; k++)
    begin
      fl <= k ? 4'b1100 : 4'b0011;
      repeat (2) @(posedge clk);
      `CHK("od pins", k ? 6'h31 : 6'h0d, lvl)
    end
    for (int c = 2; c < 4; c++)
    begin
      apb(1'b1, 8'h00, 32'(c * 5));
      repeat (2) @(posedge clk);
      for (int i = 0; i < 40; i++)
      begin
        prv = c == 2 ? {bclk[2], bclk[0]} : {bclk[3], bclk[1]};
        @(posedge clk);
        `CHK("clk pins", prv, po[1:0])
      end
    end
    // Rate index 12 of each set, read as reference edges per period
    apb(1'b1, 8'h00, 32'h01);
    apb(1'b1, 8'h20, 32'h0c);
    apb(1'b1, 8'h24, 32'h0c);
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, 8'h04, s ? 32'h80 : 32'h00);
      lo = 5 + 6 * s;
      repeat (2) @(posedge ca16);
      n = xcnt;
      @(posedge ca16);
      e = xcnt - n;
      @(posedge cb16);
      n = xcnt;
      @(posedge cb16);
      t = xcnt - n;
      prv = {e >= lo && e <= lo + 2, t >= lo && t <= lo + 2};
      `CHK("brg", 2'b11, prv)
    end
    // Counter from each source in turn, preload 2; input 2 toggles
    apb(1'b1, 8'h00, 32'h04);
    apb(1'b1, 8'h0c, 32'h02);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, 8'h04, 32'(m * 16));
      apb(1'b1, 8'h10, 32'h01);
      `CHK("ct idle", 1'b1, lvl[1])
      n = 0;
      while (lvl[1] !== 1'b0 && n < 200)
      begin
        inp[2] <= ~inp[2];
        @(posedge clk);
        n++;
      end
      `CHK("ct term", 1'b1, n > 4 && n < 200)
      apb(1'b0, 8'h14, 32'h0);
      `CHK("ct low", 2'b01, {lvl[1], rd[3]})
      apb(1'b1, 8'h10, 32'h02);
      repeat (2) @(posedge clk);
      `CHK("ct stop", 1'b1, lvl[1])
    end
    // Timer from each source; half period is 4 source edges in clocks
    apb(1'b1, 8'h0c, 32'h04);
    for (int m = 4; m < 8; m++)
    begin
      apb(1'b1, 8'h04, 32'(m * 16));
      apb(1'b1, 8'h10, 32'h01);
      lo = (m % 2 ? 16 : 1) * (m / 2 % 2 ? 16 : 8);
      // The first two halves may be cut by the restart
      for (int j = 0; j < 3; j++)
      begin
        t = 0;
        prv[0] = lvl[1];
        while (lvl[1] === prv[0] && t < 600)
        begin
          inp[2] <= ~inp[2];
          @(posedge clk);
          t++;
        end
      end
      `CHK("timer", 1'b1, t >= lo - 1 && t <= lo + 1)
    end
    inp[2] <= 1'b0;
    // Input change with enable off, then on
    apb(1'b1, 8'h04, 32'h00);
    apb(1'b1, 8'h18, 32'h80);
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b0, 8'h1c, 32'h0);
      if (s == 1)
        apb(1'b1, 8'h04, 32'h01);
      inp <= inp ^ 4'h1;
      repeat (10) @(posedge clk);
      `CHK("chg irq", s == 1, irq)
    end
    apb(1'b0, 8'h1c, 32'h0);
    repeat (3) @(posedge clk);
    `CHK("chg read", 9'h020, {rd[7:0], irq})
    apb(1'b1, 8'h18, 32'h00);
    inp <= inp ^ 4'h1;
    repeat (10) @(posedge clk);
    `CHK("masked", 1'b0, irq)
    apb(1'b1, 8'h18, 32'h80);
    repeat (2) @(posedge clk);
    `CHK("unmasked", 1'b1, irq)
    close_out();
  end
  // Watchdog against a hang
  initial
  begin
    #1000000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
